// *** logic/stu_pkg.sv ***
// Package of the two-wire status and timeout unit: SFR offsets, field positions, codes.
// Assumes an 8-bit special-function bus with one-cycle read and write strobes.
`default_nettype none
package stu_pkg;
  localparam logic [7:0] ADDR_DATA = 8'hbc;
  localparam logic [7:0] ADDR_STATE = 8'hbd;
  localparam logic [7:0] ADDR_RATE = 8'hbe;
  localparam logic [7:0] ADDR_TIMER = 8'hbf;
  localparam logic [7:0] ADDR_CTRL = 8'hc0;
  // Control register fields.
  localparam int CTRL_ENABLE = 6;
  localparam int CTRL_START = 5;
  localparam int CTRL_STOP = 4;
  localparam int CTRL_FLAG = 3;
  localparam int CTRL_ACK = 2;
  localparam logic [7:0] CTRL_MASK = 8'h7c;
  // Timer register fields.
  localparam int TMR_ENABLE = 2;
  localparam int TMR_TIMEOUT_PRESCALE_SELECT = 1;
  localparam int TMR_FLAG = 0;
  localparam logic [7:0] TMR_MASK = 8'h07;
  // Status codes defined for this unit.
  localparam logic [7:0] CODE_BUS_ERROR = 8'h00;
  localparam logic [7:0] CODE_START_SENT = 8'h08;
  localparam logic [7:0] CODE_RESTART_SENT = 8'h10;
  localparam logic [7:0] CODE_ADDR_ACK = 8'h18;
  localparam logic [7:0] CODE_ADDR_NACK = 8'h20;
  localparam logic [7:0] CODE_DATA_ACK = 8'h28;
  localparam logic [7:0] CODE_DATA_NACK = 8'h30;
  localparam logic [7:0] CODE_IDLE = 8'hf8;
  localparam int NUM_CODES = 23;
  localparam int TMO_WIDTH = 14;
  localparam logic [1:0] TIMEOUT_PRESCALE_SELECT_LAST = 2'h3;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int RATE_RESET = 4;
endpackage : stu_pkg
`default_nettype wire

// *** logic/stu_sync.sv ***
// Two-flop synchroniser for the bus pins.
// Assumes the pins are asynchronous to clk.
`default_nettype none
module stu_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic s1;
  // First flop feeds only the second.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1 <= 1'b1;
      q <= 1'b1;
    end
    else
    begin
      s1 <= d;
      q <= s1;
    end
  end
endmodule // stu_sync
`default_nettype wire

// *** logic/stu_timeout.sv ***
// Fourteen-bit timeout counter with divide-by-four prescaler.
// Assumes run and clear come from logic on the same clock.
`default_nettype none
module stu_timeout #(
  parameter int WIDTH = stu_pkg::TMO_WIDTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic clear,
  input wire logic timeout_prescale_select,
  output logic overflow
);
  import stu_pkg::*;
  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic [1:0] pre;
    logic ovf;
  } stu_tmo_t;
  stu_tmo_t st, next_st;
  logic tick;
  // Counts one step per clock, or per fourth clock when divided.
  always_comb
  begin
    next_st = st;
    tick = !timeout_prescale_select || (st.pre == TIMEOUT_PRESCALE_SELECT_LAST);
    next_st.ovf = 1'b0;
    if (clear)
    begin
      next_st.count = '0;
      next_st.pre = 2'h0;
    end
    else if (run)
    begin
      next_st.pre = st.pre + 2'h1;
      if (tick)
      begin
        next_st.count = st.count + 1'b1;
        next_st.ovf = &st.count;
      end
    end
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end
  assign overflow = st.ovf;
endmodule // stu_timeout
`default_nettype wire

// *** logic/stu_unit.sv ***
// Two-wire serial controller: status code, data, rate, timeout and control registers.
// Assumes a single-cycle SFR bus; pins are open drain with external pull-ups.
`default_nettype none
// What this block does
// - Status reads zero in bits 2..0, state code in bits 7..3.
// - Eight distinct status codes are defined; address codes 18 and 20 are never presented.
// - Idle code F8 never raises the serial interrupt flag.
// - Entering any non-idle state loads its code and sets the flag.
// - Code stays valid from one cycle after set until after clear.
// - Code 00 is reserved for bus error.
// - START or STOP in any bit of a byte but the first flags a bus error.
// - Eight-bit data register holds the byte to send; received bits are not stored.
// - Eight-bit writable rate register sets the serial clock rate.
// - Timeout counter runs only with its enable and function enable.
// - Setting the interrupt flag stops and clears the timeout counter.
// - Prescale select picks clock directly or divided by four.
// - Overflow sets sticky timeout flag and requests the interrupt.
// - Disabled: pins released, inputs ignored, stop request forced zero.
// - Flag set stretches SCL low and suspends the transfer, except when set by a bus error, which releases both pins.
// - Start request issues START when free, else after a STOP.
// - Acknowledge enable is only stored; SDA is released in the ack clock after bytes.
module stu_unit (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  output logic irq,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  import stu_pkg::*;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01, ST_START = 6'h02, ST_LOW = 6'h04,
    ST_HIGH = 6'h08, ST_STOP = 6'h10, ST_WAIT = 6'h20
  } stu_phase_t;
  typedef struct packed {
    stu_phase_t phase;
    logic [7:0] data;
    logic [4:0] code;
    logic [7:0] rate;
    logic [7:0] ctrl;
    logic [2:0] tmr;
    logic [9:0] div;
    logic [3:0] bitn;
    logic sda_drv;
    logic scl_drv;
    logic busy;
    logic scl_q;
    logic sda_q;
    logic got_ack;
    logic [7:0] rdata;
  } stu_state_t;
  stu_state_t st, next_st;
  logic scl_s, sda_s, en, flag, start_cond, stop_cond, ovf, hit;
  logic [9:0] half;
  stu_sync u_scl (.clk(clk), .rst_n(rst_n), .d(scl_in), .q(scl_s));
  stu_sync u_sda (.clk(clk), .rst_n(rst_n), .d(sda_in), .q(sda_s));
  // Timeout counter, cleared while the flag is set.
  stu_timeout #(.WIDTH(TMO_WIDTH)) u_tmo (
    .clk(clk), .rst_n(rst_n),
    .run(st.tmr[TMR_ENABLE] && en),
    .clear(flag),
    .timeout_prescale_select(st.tmr[TMR_TIMEOUT_PRESCALE_SELECT]),
    .overflow(ovf)
  );
  // Returns the value a register reads back, reserved bits as zero.
  function automatic logic [7:0] rd_mux(input stu_state_t s, input logic [7:0] a);
    case (a)
      ADDR_DATA: rd_mux = s.data;
      ADDR_STATE: rd_mux = {s.code, 3'h0};
      ADDR_RATE: rd_mux = s.rate;
      ADDR_TIMER: rd_mux = {5'h00, s.tmr};
      ADDR_CTRL: rd_mux = s.ctrl & CTRL_MASK;
      default: rd_mux = 8'h00;
    endcase
  endfunction
  assign en = st.ctrl[CTRL_ENABLE];
  assign flag = st.ctrl[CTRL_FLAG];
  assign half = {st.rate, 2'h0} + 10'h004;
  assign start_cond = en && st.scl_q && scl_s && st.sda_q && !sda_s;
  assign stop_cond = en && st.scl_q && scl_s && !st.sda_q && sda_s;
  assign hit = (st.div >= half - 10'h001);
  // Next-state logic: register writes, bus sequencer and status codes.
  always_comb
  begin
    next_st = st;
    next_st.scl_q = scl_s;
    next_st.sda_q = sda_s;
    next_st.rdata = sfr_rd ? rd_mux(st, sfr_addr) : st.rdata;
    next_st.div = st.div + 10'h001;
    if (start_cond)
      next_st.busy = 1'b1;
    if (stop_cond)
      next_st.busy = 1'b0;
    if (sfr_wr)
    begin
      case (sfr_addr)
        ADDR_DATA: next_st.data = sfr_wdata;
        ADDR_RATE: next_st.rate = sfr_wdata;
        ADDR_TIMER: next_st.tmr = {sfr_wdata[TMR_ENABLE:TMR_TIMEOUT_PRESCALE_SELECT],
                                   st.tmr[TMR_FLAG] & sfr_wdata[TMR_FLAG]};
        ADDR_CTRL: next_st.ctrl = sfr_wdata & CTRL_MASK;
        default: next_st = next_st;
      endcase
    end
    if (ovf)
      next_st.tmr[TMR_FLAG] = 1'b1;
    if (!next_st.ctrl[CTRL_ENABLE])
    begin
      next_st.ctrl[CTRL_STOP] = 1'b0;
      next_st.phase = ST_IDLE;
      next_st.scl_drv = 1'b0;
      next_st.sda_drv = 1'b0;
      next_st.busy = 1'b0;
    end
    else
    begin
      case (st.phase)
        ST_IDLE:
        begin
          next_st.div = '0;
          if (st.ctrl[CTRL_START] && !flag)
            next_st.phase = st.busy ? ST_WAIT : ST_START;
        end
        ST_WAIT:
        begin
          next_st.div = '0;
          if (!st.busy && !start_cond)
            next_st.phase = ST_START;
        end
        ST_START:
          if (hit && !st.sda_drv)
          begin
            next_st.sda_drv = 1'b1;
            next_st.div = '0;
            next_st.code = st.busy ? CODE_RESTART_SENT[7:3] : CODE_START_SENT[7:3];
          end
          else if (hit)
          begin
            next_st.scl_drv = 1'b1;
            next_st.div = '0;
            next_st.bitn = 4'h0;
            next_st.phase = ST_LOW;
            next_st.ctrl[CTRL_FLAG] = 1'b1;
          end
        // Stretch SCL low while flag set
        ST_LOW:
          if (flag)
            next_st.div = '0;
          else if (st.ctrl[CTRL_STOP])
          begin
            next_st.sda_drv = 1'b1;
            next_st.phase = ST_STOP;
            next_st.div = '0;
          end
          else if (hit)
          begin
            if (st.bitn < 4'h8)
              next_st.sda_drv = !st.data[3'h7 - st.bitn[2:0]];
            else
              next_st.sda_drv = 1'b0;
            next_st.scl_drv = 1'b0;
            next_st.div = '0;
            next_st.phase = ST_HIGH;
          end
        ST_HIGH:
          if (hit && scl_s)
          begin
            if (st.bitn == 4'h8)
            begin
              next_st.got_ack = !sda_s;
              // Enter state, load code, set flag
              next_st.code = sda_s ? CODE_DATA_NACK[7:3] : CODE_DATA_ACK[7:3];
              next_st.ctrl[CTRL_FLAG] = 1'b1;
              next_st.bitn = 4'h0;
            end
            else
              next_st.bitn = st.bitn + 4'h1;
            next_st.scl_drv = 1'b1;
            next_st.div = '0;
            next_st.phase = ST_LOW;
          end
        ST_STOP:
          if (hit)
          begin
            next_st.scl_drv = 1'b0;
            if (scl_s)
            begin
              next_st.sda_drv = 1'b0;
              next_st.ctrl[CTRL_STOP] = 1'b0;
              next_st.ctrl[CTRL_START] = 1'b0;
              next_st.code = CODE_IDLE[7:3];
              next_st.phase = ST_IDLE;
            end
          end
        default: next_st.phase = ST_IDLE;
      endcase
      if ((start_cond || stop_cond) && (st.phase == ST_HIGH) && st.bitn != 4'h0)
      begin
        next_st.code = CODE_BUS_ERROR[7:3];
        next_st.ctrl[CTRL_FLAG] = 1'b1;
        next_st.phase = ST_IDLE;
        next_st.scl_drv = 1'b0;
        next_st.sda_drv = 1'b0;
      end
    end
  end
  // State register.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.phase <= ST_IDLE;
      st.code <= CODE_IDLE[7:3];
      st.rate <= 8'(RATE_RESET);
      st.scl_q <= 1'b1;
      st.sda_q <= 1'b1;
    end
    else
      st <= next_st;
  end
  // Outputs: open-drain low drives and read data.
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = st.scl_drv;
  assign sda_oe = st.sda_drv;
  assign sfr_rdata = st.rdata;
  assign irq = flag || st.tmr[TMR_FLAG];

  AST_LOW_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    sfr_rd && sfr_addr == ADDR_STATE |=> sfr_rdata[2:0] == 3'h0)
    else $error("status low bits not zero");
  AST_IDLE_NOFLAG: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(flag) |-> st.code != CODE_IDLE[7:3])
    else $error("flag raised with idle code");
  AST_CODE_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    flag && $past(flag) && !$rose(flag) && !(start_cond || stop_cond) |-> $stable(st.code))
    else $error("code changed while flag set");
  AST_TMO_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    flag |=> !ovf)
    else $error("timeout ran while flag set");
  AST_TIF_SET: assert property (@(posedge clk) disable iff (!rst_n)
    ovf |=> st.tmr[TMR_FLAG] ##0 irq)
    else $error("overflow did not set timeout flag");
  AST_DIS_REL: assert property (@(posedge clk) disable iff (!rst_n)
    !en |-> !st.ctrl[CTRL_STOP] && !scl_oe && !sda_oe)
    else $error("disabled unit drives the bus");
  AST_STRETCH: assert property (@(posedge clk) disable iff (!rst_n)
    flag && st.phase == ST_LOW |=> scl_oe)
    else $error("clock released while flag set");
  AST_RSV_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    sfr_rd && sfr_addr == ADDR_TIMER |=> sfr_rdata[7:3] == 5'h00)
    else $error("reserved timer bits not zero");
  AST_BUS_ERR: assert property (@(posedge clk) disable iff (!rst_n)
    en && (start_cond || stop_cond) && st.phase == ST_HIGH && st.bitn != 4'h0
    |=> st.code == CODE_BUS_ERROR[7:3] && flag)
    else $error("bus error not reported");
  AST_START_SHAPE: assert property (@(posedge clk) disable iff (!rst_n)
    st.phase == ST_START && !scl_oe && next_st.scl_drv |-> sda_oe)
    else $error("clock pulled low before data at start");
endmodule // stu_unit
`default_nettype wire

// *** verification/stu_bus_model.sv ***
// Far-side stand-in: a slave that acknowledges bytes when asked.
// Assumes wired-AND bus levels with pull-ups, sampled on clk.
`default_nettype none
module stu_bus_model (
  input wire logic clk,
  input wire logic scl,
  input wire logic sda,
  input wire logic ack_on,
  input wire logic err_on,
  output logic sda_pull
);
  timeunit 1ns;
  timeprecision 1ns;
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  int falls = 0;
  logic err_pull = 1'b0;
  // Count SCL falls since START; the ninth bit of each byte is the ack slot.
  always @(posedge clk)
  begin
    scl_q <= scl;
    sda_q <= sda;
    if (scl && scl_q && sda_q && !sda)
      falls <= 0;
    else if (scl_q && !scl)
      falls <= (falls == 9) ? 1 : falls + 1;
    // When asked, pull SDA low in the second bit while SCL is high: a misplaced START.
    if (!err_on)
      err_pull <= 1'b0;
    else if (falls == 2 && scl && scl_q)
      err_pull <= 1'b1;
  end
  // Pull SDA low through the whole ack bit, then release to the pull-up.
  assign sda_pull = (ack_on && (falls == 9)) || err_pull;
endmodule // stu_bus_model
`default_nettype wire

// *** verification/stu_unit_tb.sv ***
// Self-checking bench for the status and timeout unit.
// Assumes open-drain pins with pull-ups and the slave model on the bus.
`default_nettype none
module stu_unit_tb;
  import stu_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic ack_on = 1'b1;
  logic err_on = 1'b0;
  logic [7:0] sfr_rdata;
  logic irq;
  logic scl_oe;
  logic sda_oe;
  logic pull;
  wire scl_w = ~scl_oe;
  wire sda_w = ~(sda_oe | pull);
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;

  stu_unit u_stu_unit (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .irq(irq), .scl_in(scl_w), .scl_out(),
    .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe));
  stu_bus_model u_stu_bus_model (.clk(clk), .scl(scl_w), .sda(sda_w),
    .ack_on(ack_on), .err_on(err_on), .sda_pull(pull));

  // Clock of 50 ns period.
  initial
  begin
    forever #25 clk = ~clk;
  end

  // Closing report.
  task automatic test_done();
    if (errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Compare one value and count it.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Register write, one-cycle strobe.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clk);
    #1 sfr_wr = 1'b0;
    @(posedge clk);
    #1;
  endtask

  // Register read, data checked the cycle after the strobe.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clk);
    #1 sfr_rd = 1'b0;
    @(posedge clk);
    #1 chk(sfr_rdata, e);
  endtask

  // Wait a bounded time for the interrupt line.
  task automatic wait_irq();
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 3000)
    begin
      @(posedge clk);
      #1 k++;
    end
    chk({7'h0, irq}, 8'h01);
  endtask

  // Send one byte: release the flag, capture SDA at each SCL rise.
  task automatic send(input logic [7:0] b, input logic a, input logic [7:0] code);
    logic [7:0] got;
    logic scl_p;
    int n;
    int k;
    got = 8'h00;
    scl_p = 1'b0;
    n = 0;
    k = 0;
    ack_on = a;
    wr(ADDR_DATA, b);
    wr(ADDR_CTRL, 8'h44);
    while (n < 8 && k < 2000)
    begin
      @(posedge clk);
      #1 k++;
      if (scl_w && !scl_p)
      begin
        got = {got[6:0], sda_w};
        n++;
      end
      scl_p = scl_w;
    end
    chk(got, b);
    wait_irq();
    rd(ADDR_STATE, code);
  endtask

  // Hang guard.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 95000)
    begin
      errors++;
      test_done();
    end
  end

  // Main sequence.
  initial
  begin
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    rd(ADDR_STATE, CODE_IDLE);
    rd(ADDR_RATE, 8'h04);
    rd(ADDR_TIMER, 8'h00);
    rd(ADDR_CTRL, 8'h00);
    rd(8'hc1, 8'h00);
    chk({7'h0, irq}, 8'h00);
    wr(ADDR_TIMER, 8'hfe);
    rd(ADDR_TIMER, 8'h06);
    wr(ADDR_TIMER, 8'h00);
    wr(ADDR_RATE, 8'hff);
    rd(ADDR_RATE, 8'hff);
    wr(ADDR_RATE, 8'h00);
    wr(ADDR_CTRL, 8'h30);
    rd(ADDR_CTRL, 8'h20);
    repeat (20) @(posedge clk);
    #1 chk({6'h0, scl_oe, sda_oe}, 8'h00);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_DATA, 8'ha5);
    rd(ADDR_DATA, 8'ha5);
    wr(ADDR_CTRL, 8'h64);
    wait_irq();
    rd(ADDR_STATE, CODE_START_SENT);
    repeat (20) @(posedge clk);
    #1 chk({6'h0, scl_oe, sda_oe}, 8'h03);
    send(8'ha5, 1'b1, CODE_DATA_ACK);
    send(8'h3c, 1'b0, CODE_DATA_NACK);
    wr(ADDR_CTRL, 8'h54);
    repeat (100) @(posedge clk);
    #1 chk({7'h0, irq}, 8'h00);
    rd(ADDR_STATE, CODE_IDLE);
    rd(ADDR_CTRL, 8'h44);
    chk({6'h0, scl_oe, sda_oe}, 8'h00);
    wr(ADDR_RATE, 8'h04);
    err_on = 1'b1;
    wr(ADDR_DATA, 8'hff);
    wr(ADDR_CTRL, 8'h64);
    wait_irq();
    rd(ADDR_STATE, CODE_START_SENT);
    wr(ADDR_CTRL, 8'h44);
    wait_irq();
    rd(ADDR_STATE, CODE_BUS_ERROR);
    chk({6'h0, scl_oe, sda_oe}, 8'h00);
    err_on = 1'b0;
    wr(ADDR_CTRL, 8'h44);
    chk({7'h0, irq}, 8'h00);
    wr(ADDR_TIMER, 8'h04);
    repeat (16000) @(posedge clk);
    #1 chk({7'h0, irq}, 8'h00);
    wait_irq();
    rd(ADDR_TIMER, 8'h05);
    wr(ADDR_TIMER, 8'h06);
    chk({7'h0, irq}, 8'h00);
    repeat (64000) @(posedge clk);
    #1 chk({7'h0, irq}, 8'h00);
    wait_irq();
    rd(ADDR_TIMER, 8'h07);
    test_done();
  end
endmodule // stu_unit_tb
`default_nettype wire
